// file: hdl/uim_top.sv
`timescale 1ns/1ps
module uim_top
	import uim_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic link_clk_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire uim_utmi_rx_t utmi_rx_i,
	input wire logic utmi_txready_i,
	output logic utmi_txvalid_o,
	output logic [7:0] utmi_txdata_o,
	input wire uim_phy_stat_t phy_stat_i,
	output uim_phy_ctl_t phy_ctl_o,
	input wire logic proc_tx_valid_i,
	input wire logic [7:0] proc_tx_data_i,
	output logic proc_tx_ready_o,
	output logic proc_rx_valid_o,
	output logic [7:0] proc_rx_data_o,
	output logic [2:0] flag_o
);
	// ----------------------------------------
	// Reset release, one copy per domain
	// ----------------------------------------
	logic [1:0] crst_s; // Core reset synchroniser
	logic [1:0] lrst_s; // Link reset synchroniser
	logic rst_b; // Core reset, released synchronously
	logic lrst_b; // Link reset, released synchronously

	// Assert at once, release after two edges
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			crst_s <= 2'h0;
		end else begin
			crst_s <= {crst_s[0], 1'b1};
		end
	end
	assign rst_b = crst_s[1];

	// Same release on the link clock
	always_ff @(posedge link_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lrst_s <= 2'h0;
		end else begin
			lrst_s <= {lrst_s[0], 1'b1};
		end
	end
	assign lrst_b = lrst_s[1];

	// ----------------------------------------
	// State of both domains
	// ----------------------------------------
	uim_core_t c_reg, c_next; // Processor-side registers
	uim_link_t l_reg, l_next; // Transceiver-side decoder
	uim_lcfg_t cfg_w; // Config word offered to the link
	logic [6:0] w1c; // Write-one-to-clear on flags
	logic [6:0] fset; // Flag sources this cycle
	logic [4:0] fedge; // Link events seen in core domain
	logic pkt; // Start of a packet, core domain
	logic srst_wr; // Write to the reset register
	logic [15:0] tk; // Token body, second byte live
	logic cfg_e, srst_e, tok_ok, is_sof;

	// ----------------------------------------
	// Checksum helpers, serial bit order
	// ----------------------------------------
	function automatic logic [4:0] crc5_of(input logic [10:0] d);
		logic [4:0] r;
		r = CRC5_INIT;
		for (int i = 0; i < 11; i++) begin
			r = (r >> 1) ^ ((r[0] ^ d[i]) ? CRC5_POLY : 5'h00);
		end
		return ~r;
	endfunction : crc5_of

	function automatic logic [15:0] crc16_of(input logic [15:0] s,
			input logic [7:0] d);
		logic [15:0] r;
		r = s;
		for (int i = 0; i < 8; i++) begin
			r = (r >> 1) ^ ((r[0] ^ d[i]) ? CRC16_POLY : 16'h0000);
		end
		return r;
	endfunction : crc16_of

	// ----------------------------------------
	// Core domain: register file and flags
	// ----------------------------------------
	assign srst_wr = reg_wr_i && (reg_addr_i == OFS_RST);
	assign w1c = (reg_wr_i && reg_addr_i == OFS_FLG) ?
		reg_wdata_i[6:0] : 7'h00;
	assign fedge = c_reg.ev_s2 ^ c_reg.ev_s3;
	assign pkt = c_reg.lv_s2[9] && !c_reg.act_d;
	assign fset = {fedge, c_reg.lv_s2[9], c_reg.lv_s2[10]};
	// Link only reads this after a toggle, when it is stable
	assign cfg_w = '{tok_proc: c_reg.mode[MD_TOKPROC],
		tok_chk: c_reg.mode[MD_TOKCHK], ls_dec: c_reg.mode[MD_LSDEC],
		sof_tok: c_reg.mode[MD_SOFTOK], addr: c_reg.addr,
		ep_mark: c_reg.epm};

	// Next core state
	always_comb begin
		c_next = c_reg;
		// Flags: set beats any clear but the soft reset
		for (int i = 0; i < 7; i++) begin
			if (c_reg.hold[i]) begin
				c_next.flg[i] = fset[i] | (c_reg.flg[i] & ~w1c[i]);
			end else if (i < 2) begin
				c_next.flg[i] = fset[i];
			end else begin
				c_next.flg[i] = fset[i] |
					(c_reg.flg[i] & ~w1c[i] & ~pkt);
			end
		end
		// Token fields are stable while their toggle crosses
		if (fedge[FL_TOK - 2]) begin
			c_next.pid = l_reg.pid;
			if (l_reg.pid == PID_SOF) begin
				c_next.sof = l_reg.frame;
			end else begin
				c_next.ep = {1'b1, l_reg.ep};
			end
		end
		// Flag outputs lag the flags by one cycle
		for (int k = 0; k < 3; k++) begin
			c_next.flag[k] = |(c_reg.flg & c_reg.msk[k * 8 +: 7]);
		end
		// Read port, answer on the next edge
		c_next.rvalid = reg_rd_i;
		case (reg_addr_i)
			OFS_MODE: c_next.rdata = {24'h0, c_reg.mode};
			OFS_ADDR: c_next.rdata = {25'h0, c_reg.addr};
			OFS_FUNC: c_next.rdata = {27'h0, c_reg.func};
			OFS_DRC: c_next.rdata = {24'h0, c_reg.drc};
			OFS_DRS: c_next.rdata = {26'h0, c_reg.lv_s2[5:0]};
			OFS_SER: c_next.rdata = {25'h0, c_reg.lv_s2[8:6],
				c_reg.ser};
			OFS_FLG: c_next.rdata = {25'h0, c_reg.flg};
			OFS_HOLD: c_next.rdata = {25'h0, c_reg.hold};
			OFS_MSK: c_next.rdata = {9'h0, c_reg.msk};
			OFS_SOF: c_next.rdata = {21'h0, c_reg.sof};
			OFS_PID: c_next.rdata = {28'h0, c_reg.pid};
			OFS_EP: c_next.rdata = {27'h0, c_reg.ep};
			OFS_EPM: c_next.rdata = {16'h0, c_reg.epm};
			OFS_PWR: c_next.rdata = {23'h0, c_reg.pwr};
			OFS_PHY: c_next.rdata = {13'h0, c_reg.phy};
			default: c_next.rdata = 32'h0;
		endcase
		// Writes; reserved bits are masked off
		if (reg_wr_i) begin
			case (reg_addr_i)
				OFS_MODE: begin
					c_next.mode = reg_wdata_i[7:0] & WM_MODE;
					c_next.cfg_tg = ~c_reg.cfg_tg;
				end
				OFS_ADDR: begin
					c_next.addr = reg_wdata_i[6:0];
					c_next.cfg_tg = ~c_reg.cfg_tg;
				end
				OFS_FUNC: c_next.func = reg_wdata_i[4:0];
				OFS_DRC: c_next.drc = reg_wdata_i[7:0] & WM_DRC;
				OFS_SER: c_next.ser = reg_wdata_i[3:0];
				OFS_HOLD: c_next.hold = reg_wdata_i[6:0];
				OFS_MSK: c_next.msk = reg_wdata_i[22:0] & WM_MSK;
				OFS_SOF: c_next.sof = reg_wdata_i[10:0];
				OFS_EPM: begin
					c_next.epm = reg_wdata_i[15:0];
					c_next.cfg_tg = ~c_reg.cfg_tg;
				end
				OFS_PWR: c_next.pwr = reg_wdata_i[8:0];
				OFS_PHY: c_next.phy = reg_wdata_i[18:0] & WM_PHY;
				default: ;
			endcase
		end
		// Any data resets the register file; the link is told too
		if (srst_wr) begin
			c_next = CORE_RST;
			c_next.srst_tg = ~c_reg.srst_tg;
			c_next.cfg_tg = ~c_reg.cfg_tg;
		end
		// Synchronisers run regardless of the soft reset
		c_next.ev_s1 = l_reg.ev_tg;
		c_next.ev_s2 = c_reg.ev_s1;
		c_next.ev_s3 = c_reg.ev_s2;
		c_next.lv_s1 = {utmi_rx_i.rxerror, utmi_rx_i.rxactive, phy_stat_i};
		c_next.lv_s2 = c_reg.lv_s1;
		c_next.act_d = c_reg.lv_s2[9];
	end

	// Core register
	always_ff @(posedge core_clk_i or negedge rst_b) begin
		if (!rst_b) begin
			c_reg <= CORE_RST;
		end else begin
			c_reg <= c_next;
		end
	end

	// ----------------------------------------
	// Core-driven outputs
	// ----------------------------------------
	assign reg_rdata_o = c_reg.rdata;
	assign reg_rvalid_o = c_reg.rvalid;
	assign flag_o = c_reg.flag;
	assign phy_ctl_o = '{opmode: c_reg.func[4:2],
		termselect: c_reg.func[1], xcvrselect: c_reg.func[0],
		external_bus_power_indicator: c_reg.drc[7],
		external_bus_power_drive: c_reg.drc[6], chrgvbus: c_reg.drc[4],
		dischrgvbus: c_reg.drc[3], dmpulldown: c_reg.drc[2],
		dppulldown: c_reg.drc[1], id_line_pullup: c_reg.drc[0],
		fslsserial: c_reg.ser[0], txenable_b: c_reg.ser[1],
		txdata: c_reg.ser[2], txse0: c_reg.ser[3]};

	// ----------------------------------------
	// Link domain: token decoder
	// ----------------------------------------
	assign cfg_e = l_reg.cfg_s[2] ^ l_reg.cfg_s[1];
	assign srst_e = l_reg.srst_s[2] ^ l_reg.srst_s[1];
	assign tk = {utmi_rx_i.rxdata, l_reg.b1};
	assign is_sof = l_reg.pid == PID_SOF;
	// Address filters all but frame starts; checking mode adds the checksum
	assign tok_ok = l_reg.cfg.tok_proc &&
		(!l_reg.cfg.tok_chk || crc5_of(tk[10:0]) == tk[15:11]) &&
		(is_sof ? l_reg.cfg.sof_tok : tk[6:0] == l_reg.cfg.addr);

	// Next link state
	always_comb begin
		l_next = l_reg;
		l_next.rx_vld = 1'b0;
		l_next.act_d = utmi_rx_i.rxactive;
		l_next.ls_d = utmi_rx_i.linestate;
		l_next.cfg_s = {l_reg.cfg_s[1:0], c_reg.cfg_tg};
		l_next.srst_s = {l_reg.srst_s[1:0], c_reg.srst_tg};
		if (cfg_e) begin
			l_next.cfg = cfg_w;
		end
		// Line state changes, one event per new SE0, K or J symbol
		if (l_reg.cfg.ls_dec && utmi_rx_i.linestate != l_reg.ls_d) begin
			case (utmi_rx_i.linestate)
				LS_SE0: l_next.ev_tg[FL_SE0 - 2] = ~l_reg.ev_tg[FL_SE0 - 2];
				LS_K: l_next.ev_tg[FL_K - 2] = ~l_reg.ev_tg[FL_K - 2];
				LS_J: l_next.ev_tg[FL_J - 2] = ~l_reg.ev_tg[FL_J - 2];
				default: ;
			endcase
		end
		// Without token processing every byte is passed raw
		if (!l_reg.cfg.tok_proc && utmi_rx_i.rxvalid) begin
			l_next.rx_vld = 1'b1;
			l_next.rx_dat = utmi_rx_i.rxdata;
		end
		case (l_reg.st)
			LK_IDLE: begin
				if (utmi_rx_i.rxactive && !l_reg.act_d) begin
					l_next.st = LK_PID;
				end
			end
			LK_PID: begin
				if (!utmi_rx_i.rxactive) begin
					l_next.st = LK_IDLE;
				end else if (utmi_rx_i.rxvalid) begin
					l_next.pid = utmi_rx_i.rxdata[3:0];
					l_next.crc = CRC16_INIT;
					// Bad check nibble drops the packet
					if (utmi_rx_i.rxdata[7:4] != ~utmi_rx_i.rxdata[3:0]) begin
						l_next.st = LK_IDLE;
					end else if (utmi_rx_i.rxdata[1:0] == PT_TOKEN) begin
						l_next.st = LK_ADR;
					end else if (utmi_rx_i.rxdata[1:0] == PT_DATA) begin
						l_next.st = LK_DATA;
					end else begin
						l_next.st = LK_IDLE;
					end
				end
			end
			LK_ADR: begin
				if (!utmi_rx_i.rxactive) begin
					l_next.st = LK_IDLE;
				end else if (utmi_rx_i.rxvalid) begin
					l_next.b1 = utmi_rx_i.rxdata;
					l_next.st = LK_CRC;
				end
			end
			LK_CRC: begin
				if (!utmi_rx_i.rxactive) begin
					l_next.st = LK_IDLE;
				end else if (utmi_rx_i.rxvalid) begin
					l_next.st = LK_IDLE;
					// Data that follows passes only after a good token
					if (!is_sof) begin
						l_next.pass_en = tok_ok;
					end
					if (tok_ok) begin
						l_next.ev_tg[FL_TOK - 2] = ~l_reg.ev_tg[FL_TOK - 2];
						l_next.ep = tk[10:7];
						l_next.frame = tk[10:0];
						if (!is_sof) begin
							l_next.rx_vld = 1'b1;
							l_next.rx_dat = {3'h0, l_reg.cfg.ep_mark[tk[10:7]],
								tk[10:7]};
						end
					end
				end
			end
			LK_DATA: begin
				if (!utmi_rx_i.rxactive) begin
					l_next.st = LK_IDLE;
					if (l_reg.crc != CRC16_RES) begin
						l_next.ev_tg[FL_CRC - 2] = ~l_reg.ev_tg[FL_CRC - 2];
					end
				end else if (utmi_rx_i.rxvalid) begin
					l_next.crc = crc16_of(l_reg.crc, utmi_rx_i.rxdata);
					if (l_reg.pass_en) begin
						l_next.rx_vld = 1'b1;
						l_next.rx_dat = utmi_rx_i.rxdata;
					end
				end
			end
			default: l_next.st = LK_IDLE;
		endcase
		// Soft reset idles the decoder; the core resets the transceiver controls
		if (srst_e) begin
			l_next.st = LK_IDLE;
			l_next.pass_en = 1'b0;
			l_next.rx_vld = 1'b0;
		end
	end

	// Link register
	always_ff @(posedge link_clk_i or negedge lrst_b) begin
		if (!lrst_b) begin
			l_reg <= LINK_RST;
		end else begin
			l_reg <= l_next;
		end
	end

	// ----------------------------------------
	// Link-driven ports
	// ----------------------------------------
	assign proc_rx_valid_o = l_reg.rx_vld;
	assign proc_rx_data_o = l_reg.rx_dat;
	assign utmi_txvalid_o = proc_tx_valid_i;
	assign utmi_txdata_o = proc_tx_data_i;
	assign proc_tx_ready_o = utmi_txready_i;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [7:0] wlo; // Low write byte for history
	logic se0_tg, crc_tg, tok_tg;
	assign wlo = reg_wdata_i[7:0];
	assign se0_tg = l_reg.ev_tg[3];
	assign crc_tg = l_reg.ev_tg[0];
	assign tok_tg = l_reg.ev_tg[4];

	AST_SRST: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		srst_wr |=> c_reg.mode == 8'h00 && c_reg.func == 5'h07 &&
		c_reg.flg == 7'h00 && c_reg.ser == 4'h2)
		else $error("soft reset left state");
	AST_MODE: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		reg_wr_i && reg_addr_i == 8'h04 |=> c_reg.mode == ($past(wlo) & 8'hf7))
		else $error("mode write lost");
	AST_ADDR: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		reg_wr_i && reg_addr_i == 8'h08 |=>
		{1'b0, c_reg.addr} == ($past(wlo) & 8'h7f))
		else $error("address write lost");
	AST_OPMODE: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		reg_wr_i && reg_addr_i == 8'h0c |=>
		{5'h0, phy_ctl_o.opmode} == (($past(wlo) >> 2) & 8'h07))
		else $error("operating mode wrong");
	AST_TXEN: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		reg_wr_i && reg_addr_i == 8'h18 && !wlo[1] |=> !phy_ctl_o.txenable_b)
		else $error("transmit enable not low");
	AST_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		c_reg.hold[6] && c_reg.flg[6] && !srst_wr && w1c == 7'h00
		|=> c_reg.flg[6])
		else $error("held flag dropped");
	AST_RXACT: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		!c_reg.hold[1] && !srst_wr |=> c_reg.flg[1] == $past(c_reg.lv_s2[9]))
		else $error("active flag not following");
	AST_PORT: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		!srst_wr && (c_reg.flg & c_reg.msk[6:0]) != 7'h00
		|=> flag_o[0])
		else $error("flag output not raised");
	AST_RO: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		reg_rd_i && reg_addr_i == 8'h14 |=>
		reg_rvalid_o && reg_rdata_o[31:6] == 26'h0)
		else $error("reserved bits not zero");
	AST_SE0: assert property (@(posedge link_clk_i) disable iff (!lrst_b)
		l_reg.cfg.ls_dec && utmi_rx_i.linestate == 2'h0 && l_reg.ls_d != 2'h0
		|=> $changed(se0_tg))
		else $error("SE0 event missed");
	AST_CRC: assert property (@(posedge link_clk_i) disable iff (!lrst_b)
		l_reg.st == LK_DATA && !utmi_rx_i.rxactive && l_reg.crc != 16'hb001
		|=> $changed(crc_tg))
		else $error("checksum error missed");
	AST_TOK: assert property (@(posedge link_clk_i) disable iff (!lrst_b)
		$changed(tok_tg) |-> $past(l_reg.st) == LK_CRC)
		else $error("token event out of place");
endmodule : uim_top

// file: shared/uim_pkg.sv
package uim_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_RST = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_ADDR = 8'h08;
	localparam logic [7:0] OFS_FUNC = 8'h0c;
	localparam logic [7:0] OFS_DRC = 8'h10;
	localparam logic [7:0] OFS_DRS = 8'h14;
	localparam logic [7:0] OFS_SER = 8'h18;
	localparam logic [7:0] OFS_FLG = 8'h1c;
	localparam logic [7:0] OFS_HOLD = 8'h20;
	localparam logic [7:0] OFS_MSK = 8'h24;
	localparam logic [7:0] OFS_SOF = 8'h28;
	localparam logic [7:0] OFS_PID = 8'h2c;
	localparam logic [7:0] OFS_EP = 8'h30;
	localparam logic [7:0] OFS_EPM = 8'h34;
	localparam logic [7:0] OFS_PWR = 8'h38;
	localparam logic [7:0] OFS_PHY = 8'h3c;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MD_TOKPROC = 0; // token_processing_mode
	localparam int MD_TOKCHK = 1; // token_checking_mode
	localparam int MD_LSDEC = 2; // line state decoder
	localparam int MD_SOFTOK = 6; // frame_start_as_token_mode
	localparam int FL_TOK = 6;
	localparam int FL_SE0 = 5;
	localparam int FL_K = 4;
	localparam int FL_J = 3;
	localparam int FL_CRC = 2;
	localparam int FL_ACT = 1;
	// ----------------------------------------
	// Reset values and writable masks
	// ----------------------------------------
	localparam logic [4:0] RST_FUNC = 5'h07;
	localparam logic [3:0] RST_SER = 4'h2;
	localparam logic [7:0] WM_MODE = 8'hf7;
	localparam logic [7:0] WM_DRC = 8'hdf;
	localparam logic [22:0] WM_MSK = 23'h7f7f7f;
	localparam logic [18:0] WM_PHY = 19'h43ff0;
	// ----------------------------------------
	// Line codes, packet ids and checksums
	// ----------------------------------------
	localparam logic [1:0] LS_SE0 = 2'h0;
	localparam logic [1:0] LS_J = 2'h1;
	localparam logic [1:0] LS_K = 2'h2;
	localparam logic [1:0] PT_TOKEN = 2'h1;
	localparam logic [1:0] PT_DATA = 2'h3;
	localparam logic [3:0] PID_SOF = 4'h5;
	localparam logic [4:0] CRC5_INIT = 5'h1f;
	localparam logic [4:0] CRC5_POLY = 5'h14;
	localparam logic [15:0] CRC16_INIT = 16'hffff;
	localparam logic [15:0] CRC16_POLY = 16'ha001;
	localparam logic [15:0] CRC16_RES = 16'hb001;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] linestate;
		logic rxactive;
		logic rxvalid;
		logic rxerror;
		logic [7:0] rxdata;
	} uim_utmi_rx_t;
	typedef struct packed {
		logic rxrcv, rxdm, rxdp, bvalid, idgnd, hostdis, vbusvld;
		logic sessvld, sessend;
	} uim_phy_stat_t;
	typedef struct packed {
		logic [2:0] opmode;
		logic termselect, xcvrselect;
		logic external_bus_power_indicator, external_bus_power_drive;
		logic chrgvbus, dischrgvbus, dmpulldown, dppulldown;
		logic id_line_pullup;
		logic fslsserial, txenable_b, txdata, txse0;
	} uim_phy_ctl_t;
	typedef enum logic [2:0] {
		LK_IDLE = 3'b000,
		LK_PID = 3'b001,
		LK_ADR = 3'b011,
		LK_CRC = 3'b010,
		LK_DATA = 3'b110
	} uim_lk_st_t;
	typedef struct packed {
		logic tok_proc, tok_chk, ls_dec, sof_tok;
		logic [6:0] addr;
		logic [15:0] ep_mark;
	} uim_lcfg_t;
	// ----------------------------------------
	// Module state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] mode;
		logic [6:0] addr;
		logic [4:0] func;
		logic [7:0] drc;
		logic [3:0] ser;
		logic [6:0] flg, hold;
		logic [22:0] msk;
		logic [10:0] sof;
		logic [3:0] pid;
		logic [4:0] ep;
		logic [15:0] epm;
		logic [8:0] pwr;
		logic [18:0] phy;
		logic cfg_tg, srst_tg, act_d, rvalid;
		logic [4:0] ev_s1, ev_s2, ev_s3;
		logic [10:0] lv_s1, lv_s2;
		logic [31:0] rdata;
		logic [2:0] flag;
	} uim_core_t;
	typedef struct packed {
		uim_lk_st_t st;
		uim_lcfg_t cfg;
		logic [2:0] cfg_s, srst_s;
		logic [3:0] pid, ep;
		logic [7:0] b1, rx_dat;
		logic [15:0] crc;
		logic [4:0] ev_tg;
		logic [10:0] frame;
		logic [1:0] ls_d;
		logic pass_en, rx_vld, act_d;
	} uim_link_t;
	localparam uim_core_t CORE_RST =
		'{func: RST_FUNC, ser: RST_SER, default: '0};
	localparam uim_link_t LINK_RST = '{st: LK_IDLE, default: '0};
endpackage : uim_pkg

// file: verification/uim_phy_model.sv
`timescale 1ns/1ps
module uim_phy_model
	import uim_pkg::*;
(
	input wire logic link_clk_i,
	output uim_utmi_rx_t utmi_rx_o
);
	// ----------------------------------------
	// Transceiver receive side
	// ----------------------------------------
	// Idle: no frame, line resting at J
	initial begin
		utmi_rx_o = '0;
		utmi_rx_o.linestate = LS_J;
	end
	// Line state change between frames
	task line(input logic [1:0] ls);
		@(posedge link_clk_i);
		utmi_rx_o.linestate <= ls;
	endtask : line
	// One frame of n bytes, byte 0 in the low bits
	task send(input int n, input logic [31:0] b);
		int i;
		@(posedge link_clk_i);
		utmi_rx_o.rxactive <= 1'b1;
		for (i = 0; i < n; i++) begin
			@(posedge link_clk_i);
			utmi_rx_o.rxvalid <= 1'b1;
			utmi_rx_o.rxdata <= b[8*i +: 8];
		end
		@(posedge link_clk_i);
		utmi_rx_o.rxactive <= 1'b0;
		utmi_rx_o.rxvalid <= 1'b0;
		// Released bus must not keep showing the last byte
		utmi_rx_o.rxdata <= ~b[8*(n-1) +: 8];
		repeat (4) @(posedge link_clk_i);
	endtask : send
endmodule : uim_phy_model

// file: verification/uim_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
	err_count++; $display("Error %0t: got %h exp %h", $time, a, e); end end
module uim_top_tb;
	import uim_pkg::*;
	// ----------------------------------------
	// Bench signals
	// ----------------------------------------
	logic core_clk = 0, link_clk = 0, rst_b, wr, rd, rvalid;
	logic [7:0] addr, txdata, ptd, prd, rx_byte;
	logic [31:0] wdata, rdata, rd_d;
	logic txready, txvalid, ptv, ptr, prv;
	logic [2:0] flag;
	uim_utmi_rx_t rx;
	uim_phy_stat_t stat;
	uim_phy_ctl_t ctl;
	int err_count = 0, num_checks = 0, rx_cnt = 0, n;
	// Register table: offset, reset value, value after all-ones write
	logic [7:0] ra [7] = '{OFS_MODE, OFS_ADDR, OFS_FUNC, OFS_DRC,
		OFS_DRS, OFS_SER, 8'h40};
	logic [31:0] rv [7] = '{0, 0, 32'h7, 0, 32'h25, 32'h62, 0};
	logic [31:0] wv [7] = '{32'hf7, 32'h7f, 32'h1f, 32'hdf, 32'h25,
		32'h6f, 0};
	// ----------------------------------------
	// Clocks, unrelated in phase
	// ----------------------------------------
	initial forever #10 core_clk = ~core_clk;
	initial begin
		#3;
		forever #7.5 link_clk = ~link_clk;
	end
	uim_top uim_top_i (.core_clk_i(core_clk), .rst_b_i(rst_b),
		.link_clk_i(link_clk), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .utmi_rx_i(rx), .utmi_txready_i(txready),
		.utmi_txvalid_o(txvalid), .utmi_txdata_o(txdata),
		.phy_stat_i(stat), .phy_ctl_o(ctl), .proc_tx_valid_i(ptv),
		.proc_tx_data_i(ptd), .proc_tx_ready_o(ptr),
		.proc_rx_valid_o(prv), .proc_rx_data_o(prd), .flag_o(flag));
	uim_phy_model uim_phy_model_i (.link_clk_i(link_clk), .utmi_rx_o(rx));
	// Count forwarded bytes; output stands one link cycle
	always @(posedge link_clk) begin
		if (prv === 1'b1) begin
			rx_cnt++;
			rx_byte = prd;
		end
	end
	// ----------------------------------------
	// Register access and helpers
	// ----------------------------------------
	task wr32(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask : wr32
	// Read answer is registered: look just after the taking edge
	task rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd <= 1'b0;
		#1;
		rd_d = rdata;
		`CHK(rvalid, 1'b1)
		`CHK(rd_d, e)
	endtask : rchk
	task cw(input int k);
		repeat (k) @(posedge core_clk);
	endtask : cw
	// Token bytes with the wire checksum, sent low bit first
	function automatic logic [31:0] tok(input logic [6:0] ad,
		input logic [3:0] ep);
		logic [10:0] v;
		logic [4:0] c;
		int i;
		v = {ep, ad};
		c = 5'h1f;
		for (i = 0; i < 11; i++) begin
			c = (c[0] ^ v[i]) ? ((c >> 1) ^ 5'h14) : (c >> 1);
		end
		return {8'h00, ~c, ep[3:1], ep[0], ad, 8'he1};
	endfunction : tok
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		int i;
		for (i = 0; i < 7; i++) rchk(ra[i], rv[i]);
		`CHK(ctl, 16'h3804)
		for (i = 0; i < 7; i++) wr32(ra[i], 32'hffffffff);
		wr32(OFS_RST, 32'h0);
		for (i = 0; i < 7; i++) wr32(ra[i], 32'hffffffff);
		for (i = 0; i < 7; i++) rchk(ra[i], wv[i]);
		`CHK(ctl, 16'hffff)
		wr32(OFS_RST, 32'h12345678);
		cw(2);
		rchk(OFS_DRC, 32'h0);
		rchk(OFS_FUNC, 32'h7);
		`CHK(ctl, 16'h3804)
		$display("test regs done");
	endtask : t_regs
	task t_pass;
		@(posedge core_clk);
		ptv <= 1'b1;
		ptd <= 8'ha5;
		txready <= 1'b1;
		@(posedge core_clk);
		#1;
		`CHK({txvalid, txdata, ptr}, 10'h34b)
		@(posedge core_clk);
		ptv <= 1'b0;
		$display("test pass done");
	endtask : t_pass
	task t_line;
		wr32(OFS_MODE, 32'h4);
		cw(8);
		uim_phy_model_i.line(LS_K);
		cw(10);
		rchk(OFS_FLG, 32'h10);
		uim_phy_model_i.line(LS_SE0);
		cw(10);
		rchk(OFS_FLG, 32'h30);
		uim_phy_model_i.line(LS_J);
		cw(10);
		rchk(OFS_FLG, 32'h38);
		// Token processing off: every byte goes out raw
		n = rx_cnt;
		uim_phy_model_i.send(2, 32'h5aa5);
		cw(5);
		`CHK(rx_cnt, n + 2)
		`CHK(rx_byte, 8'h5a)
		$display("test line done");
	endtask : t_line
	task t_token;
		wr32(OFS_ADDR, 32'h5);
		wr32(OFS_EPM, 32'h8);
		wr32(OFS_MODE, 32'h7);
		wr32(OFS_MSK, 32'h440);
		cw(10);
		n = rx_cnt;
		uim_phy_model_i.send(3, tok(7'h5, 4'h3));
		cw(10);
		`CHK(rx_cnt, n + 1)
		`CHK(rx_byte, 8'h13)
		rchk(OFS_FLG, 32'h40);
		`CHK(flag, 3'b001)
		// Wrong address, then a broken checksum: both dropped
		uim_phy_model_i.send(3, tok(7'h6, 4'h3));
		uim_phy_model_i.send(3, tok(7'h5, 4'h3) ^ 32'h800000);
		cw(10);
		`CHK(rx_cnt, n + 1)
		rchk(OFS_FLG, 32'h0);
		wr32(OFS_HOLD, 32'h40);
		uim_phy_model_i.send(3, tok(7'h5, 4'h3));
		uim_phy_model_i.send(4, 32'h000034c3);
		cw(10);
		`CHK(rx_cnt, n + 5)
		rchk(OFS_FLG, 32'h44);
		`CHK(flag, 3'b011)
		wr32(OFS_FLG, 32'h40);
		cw(5);
		rchk(OFS_FLG, 32'h04);
		// Frame start as token: frame number kept, no byte out
		wr32(OFS_MODE, 32'h47);
		cw(10);
		n = rx_cnt;
		uim_phy_model_i.send(3, tok(7'h5, 4'h3) ^ 32'h44);
		cw(10);
		`CHK(rx_cnt, n)
		rchk(OFS_SOF, 32'h185);
		rchk(OFS_PID, 32'h5);
		rchk(OFS_EP, 32'h13);
		$display("test token done");
	endtask : t_token
	// ----------------------------------------
	// Verdict, main sequence and watchdog
	// ----------------------------------------
	task results;
		$display("Checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results
	initial begin
		wr = 0;
		rd = 0;
		addr = '0;
		wdata = '0;
		rst_b = 0;
		txready = 0;
		ptv = 0;
		ptd = '0;
		stat = 9'h1a5;
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_regs();
		t_pass();
		t_line();
		t_token();
		results();
	end
	// Whole run needs under 6 us; allow over thirty times that
	initial begin
		#200000;
		err_count++;
		results();
	end
endmodule : uim_top_tb
